// File: hdl/amp_ctrl_defines.svh
// Constants for the amplifier mode control block
`ifndef AMP_CTRL_DEFINES_SVH
`define AMP_CTRL_DEFINES_SVH
`define ADDR_FIXED 5'h1b
`define NUM_REGS 6
`define REG_R_BRIDGED 3'h0
`define REG_L_BRIDGED 3'h1
`define REG_R_SINGLE 3'h2
`define REG_L_SINGLE 3'h3
`define REG_MASK 3'h4
`define REG_CTRL 3'h5
`define GAIN_RST 8'h3f
`define MASK_RST 8'hff
`define CTRL_RST 8'h00
`define MASK_SLEEP 0
`define MASK_CFG 1
`define MASK_TONE 2
`define MASK_PWRUP 7
`define CTRL_SLEEP 0
`define CTRL_HPLINE 1
`define CTRL_MUTE 3
`define CTRL_CFG 5
`define CTRL_GSEL 6
`define CTRL_TONE 7
`define TONE_EDGES 4'h8
`define TONE_GAP_NS 50000
`define CLK_NS 50
`define TONE_GAP_CYC ((`TONE_GAP_NS) / (`CLK_NS))
`define PWRUP_CYC 16'h0100
`endif

// File: hdl/amp_ctrl_pkg.sv
// Types for the amplifier mode control block
package amp_ctrl_pkg;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_ADDR = 3'b001,
      ST_WR = 3'b011,
      ST_RD = 3'b010,
      ST_SKIP = 3'b110
   } i2c_state_t;
   typedef enum logic [1:0] {
      SRC_LINE = 2'h0,
      SRC_HP = 2'h1,
      SRC_TONE = 2'h2
   } src_t;
endpackage

// File: hdl/sync2.sv
// Two-flop synchroniser, one per bit
`timescale 1ns/100ps
module sync2 #(
   parameter int W = 1,
   // Reset level per bit, so idle-high lines start at their idle level
   parameter logic [W-1:0] RST_VAL = '0
) (
   input wire logic i_sys_clk,
   input wire logic i_rst_n,
   input wire logic [W-1:0] i_async,
   output logic [W-1:0] o_sync
);
   logic [W-1:0] meta_q;
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         meta_q <= RST_VAL;
         o_sync <= RST_VAL;
      end else begin
         meta_q <= i_async;
         o_sync <= meta_q;
      end
   end
endmodule

// File: hdl/tone_detect.sv
// Tone presence detector: counts rising edges, drops on silence
`timescale 1ns/100ps
`include "amp_ctrl_defines.svh"
module tone_detect #(
   parameter int GAP_CYC = `TONE_GAP_CYC
) (
   input wire logic i_sys_clk,
   input wire logic i_rst_n,
   input wire logic i_tone,
   output logic o_present
);
   logic prev_q;
   logic [3:0] edges_q;
   logic [15:0] gap_q;
   logic rise;
   assign rise = i_tone & ~prev_q;
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         prev_q <= 1'b0;
      end else begin
         prev_q <= i_tone;
      end
   end
   // Edge count, restarted whenever the input goes quiet
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         edges_q <= 4'h0;
         gap_q <= 16'h0000;
         o_present <= 1'b0;
      end else if (rise) begin
         gap_q <= 16'h0000;
         if (edges_q < `TONE_EDGES) begin
            edges_q <= edges_q + 4'h1;
         end
         if (edges_q + 4'h1 >= `TONE_EDGES) begin
            o_present <= 1'b1;
         end
      end else if (gap_q >= 16'(GAP_CYC)) begin
         edges_q <= 4'h0;
         o_present <= 1'b0;
      end else begin
         gap_q <= gap_q + 16'h0001;
      end
   end
   a_tone_after_edges: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      $rose(o_present) |-> $past(rise)) else $error("tone present without an edge");
   a_tone_edge_count: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      $rose(o_present) |-> $past(edges_q) == (`TONE_EDGES - 4'h1)) else $error("tone present too early");
endmodule

// File: hdl/amp_mode_control_i2c_slave.sv
// Amplifier mode control with I2C slave register access
`timescale 1ns/100ps
`include "amp_ctrl_defines.svh"
module amp_mode_control_i2c_slave
   import amp_ctrl_pkg::*;
#(
   parameter int GAP_CYC = `TONE_GAP_CYC
) (
   input wire logic i_sys_clk,
   input wire logic i_rst_n,
   input wire logic i_scl,
   input wire logic i_sda,
   output logic o_sda,
   output logic o_sda_oe,
   input wire logic i_output_config_select,
   input wire logic i_sleep_request_n,
   input wire logic i_system_tone_input,
   input wire logic i_addr_strap_hi,
   input wire logic i_addr_strap_lo,
   output logic o_follower_en,
   output logic o_single_ended_mode,
   output src_t o_input_src,
   output logic o_gain_bank_single,
   output logic o_tone_fixed_gain,
   output logic [5:0] o_gain_right,
   output logic [5:0] o_gain_left,
   output logic o_mute,
   output logic o_sleep
);
   // ****************************************
   // Input synchronisers
   // ****************************************
   logic [6:0] pins_s;
   logic scl_s, sda_s, cfg_s, sleep_n_s, tone_s, strap_hi_s, strap_lo_s;
   // Clock, data and sleep request idle high; a zero reset would fake edges
   sync2 #(.W(7), .RST_VAL(7'h68)) u_sync (
      .i_sys_clk(i_sys_clk),
      .i_rst_n(i_rst_n),
      .i_async({i_scl, i_sda, i_output_config_select, i_sleep_request_n,
                i_system_tone_input, i_addr_strap_hi, i_addr_strap_lo}),
      .o_sync(pins_s)
   );
   assign {scl_s, sda_s, cfg_s, sleep_n_s, tone_s, strap_hi_s, strap_lo_s} = pins_s;

   logic scl_q, sda_q;
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end else begin
         scl_q <= scl_s;
         sda_q <= sda_s;
      end
   end
   logic scl_rise, scl_fall, start_c, stop_c;
   assign scl_rise = scl_s & ~scl_q;
   assign scl_fall = ~scl_s & scl_q;
   assign start_c = scl_s & scl_q & sda_q & ~sda_s;
   assign stop_c = scl_s & scl_q & ~sda_q & sda_s;

   // Address caught after reset release, not under the reset itself
   logic [6:0] own_addr_q;
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         own_addr_q <= 7'h00;
      end else begin
         own_addr_q <= {`ADDR_FIXED, strap_hi_s, strap_lo_s};
      end
   end

   // ****************************************
   // I2C slave engine
   // ****************************************
   i2c_state_t state_q;
   logic [3:0] bit_q;
   logic [7:0] sh_q;
   logic [2:0] idx_q;
   logic ack_q;
   logic [7:0] regs_q [`NUM_REGS];
   logic [15:0] pwrup_q;
   logic [7:0] rd_byte;
   logic [2:0] idx_nx;
   logic [7:0] rd_next;
   logic wr_strobe;
   logic [7:0] wr_byte;
   assign rd_byte = (idx_q == `REG_MASK) ? {(pwrup_q != 16'h0000), regs_q[`REG_MASK][6:0]} :
                    (idx_q < 3'(`NUM_REGS)) ? regs_q[idx_q] : 8'h00;
   assign wr_byte = {sh_q[6:0], sda_s};
   assign idx_nx = idx_q + 3'h1;
   assign rd_next = (idx_nx == `REG_MASK) ? {(pwrup_q != 16'h0000), regs_q[`REG_MASK][6:0]} :
                    (idx_nx < 3'(`NUM_REGS)) ? regs_q[idx_nx] : 8'h00;

   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state_q <= ST_IDLE;
         bit_q <= 4'h0;
         sh_q <= 8'h00;
         idx_q <= 3'h0;
         ack_q <= 1'b0;
      end else if (start_c) begin
         state_q <= ST_ADDR;
         // Start's own clock fall wraps this to zero before the first bit
         bit_q <= 4'hf;
         idx_q <= 3'h0;
         ack_q <= 1'b0;
      end else if (stop_c) begin
         state_q <= ST_IDLE;
      end else begin
         case (state_q)
            ST_ADDR, ST_WR: begin
               if (scl_rise && bit_q < 4'h8) begin
                  sh_q <= wr_byte;
               end
               if (scl_fall) begin
                  if (bit_q == 4'h7) begin
                     bit_q <= 4'h8;
                     if (state_q == ST_ADDR) begin
                        ack_q <= (sh_q[7:1] == own_addr_q);
                     end else begin
                        ack_q <= 1'b1;
                     end
                  end else if (bit_q == 4'h8) begin
                     bit_q <= 4'h0;
                     ack_q <= 1'b0;
                     if (state_q == ST_ADDR) begin
                        if (!ack_q) begin
                           state_q <= ST_SKIP;
                        end else if (sh_q[0]) begin
                           state_q <= ST_RD;
                           sh_q <= rd_byte;
                        end else begin
                           state_q <= ST_WR;
                        end
                     end else if (idx_q < 3'(`NUM_REGS)) begin
                        idx_q <= idx_q + 3'h1;
                     end
                  end else begin
                     bit_q <= bit_q + 4'h1;
                  end
               end
            end
            ST_RD: begin
               if (scl_rise && bit_q == 4'h8 && sda_s) begin
                  state_q <= ST_SKIP;
               end else if (scl_fall) begin
                  if (bit_q == 4'h8) begin
                     bit_q <= 4'h0;
                     idx_q <= idx_q + 3'h1;
                     sh_q <= rd_next;
                  end else begin
                     bit_q <= bit_q + 4'h1;
                     if (bit_q != 4'h7) begin
                        sh_q <= {sh_q[6:0], 1'b0};
                     end
                  end
               end
            end
            default: begin
            end
         endcase
      end
   end

   assign wr_strobe = (state_q == ST_WR) && scl_fall && bit_q == 4'h7 && !start_c && !stop_c;

   // Data only on SCL low phase, released for the master's ack bit
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_sda <= 1'b0;
         o_sda_oe <= 1'b0;
      end else begin
         o_sda <= 1'b0;
         if (start_c || stop_c) begin
            o_sda_oe <= 1'b0;
         end else if (scl_fall) begin
            if ((state_q == ST_ADDR || state_q == ST_WR) && bit_q == 4'h7) begin
               o_sda_oe <= (state_q == ST_WR) || (sh_q[7:1] == own_addr_q);
            end else if (state_q == ST_RD && bit_q != 4'h7) begin
               o_sda_oe <= bit_q == 4'h8 ? ~rd_next[7] : ~sh_q[6];
            end else if (state_q == ST_ADDR && bit_q == 4'h8 && ack_q && sh_q[0]) begin
               o_sda_oe <= ~rd_byte[7];
            end else begin
               o_sda_oe <= 1'b0;
            end
         end else if (state_q == ST_SKIP || state_q == ST_IDLE) begin
            o_sda_oe <= 1'b0;
         end
      end
   end

   // ****************************************
   // Register file
   // ****************************************
   // Bytes land in order; a short write still updates the early registers
   genvar g;
   generate
      for (g = 0; g < `NUM_REGS; g++) begin : g_reg
         localparam logic [7:0] RST = (g == `REG_MASK) ? `MASK_RST :
                                      (g == `REG_CTRL) ? `CTRL_RST : `GAIN_RST;
         always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
            if (!i_rst_n) begin
               regs_q[g] <= RST;
            end else if (wr_strobe && idx_q == 3'(g)) begin
               regs_q[g] <= sh_q;
            end
         end
      end
   endgenerate

   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         pwrup_q <= `PWRUP_CYC;
      end else if (pwrup_q != 16'h0000) begin
         pwrup_q <= pwrup_q - 16'h0001;
      end
   end

   // ****************************************
   // Mode resolution
   // ****************************************
   logic [7:0] mask_r, ctrl_r;
   logic tone_present, tone_on, cfg_single, sleep_req, hp_sel, gsel_single;
   assign mask_r = regs_q[`REG_MASK];
   assign ctrl_r = regs_q[`REG_CTRL];

   tone_detect #(.GAP_CYC(GAP_CYC)) u_tone (
      .i_sys_clk(i_sys_clk),
      .i_rst_n(i_rst_n),
      .i_tone(tone_s),
      .o_present(tone_present)
   );

   // Tone overrides only the outputs; stored mode is untouched, so it returns
   assign tone_on = (mask_r[`MASK_TONE] || !ctrl_r[`CTRL_TONE]) ? tone_present : 1'b1;
   assign cfg_single = mask_r[`MASK_CFG] ? cfg_s : ctrl_r[`CTRL_CFG];
   assign hp_sel = mask_r[`MASK_CFG] ? cfg_s : ctrl_r[`CTRL_HPLINE];
   assign gsel_single = mask_r[`MASK_CFG] ? cfg_s : ctrl_r[`CTRL_GSEL];
   assign sleep_req = mask_r[`MASK_SLEEP] ? !sleep_n_s : ctrl_r[`CTRL_SLEEP];

   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_follower_en <= 1'b1;
         o_single_ended_mode <= 1'b0;
         o_input_src <= SRC_LINE;
         o_gain_bank_single <= 1'b0;
         o_tone_fixed_gain <= 1'b0;
         o_gain_right <= 6'h3f;
         o_gain_left <= 6'h3f;
         o_mute <= 1'b1;
         o_sleep <= 1'b0;
      end else if (tone_on) begin
         o_follower_en <= 1'b1;
         o_single_ended_mode <= 1'b0;
         o_input_src <= SRC_TONE;
         o_tone_fixed_gain <= 1'b1;
         o_mute <= 1'b0;
         o_sleep <= 1'b0;
      end else begin
         o_follower_en <= !cfg_single;
         o_single_ended_mode <= cfg_single;
         o_input_src <= hp_sel ? SRC_HP : SRC_LINE;
         o_gain_bank_single <= gsel_single;
         o_tone_fixed_gain <= 1'b0;
         o_gain_right <= gsel_single ? regs_q[`REG_R_SINGLE][5:0] : regs_q[`REG_R_BRIDGED][5:0];
         o_gain_left <= gsel_single ? regs_q[`REG_L_SINGLE][5:0] : regs_q[`REG_L_BRIDGED][5:0];
         o_mute <= sleep_req || ctrl_r[`CTRL_MUTE] ||
                   (gsel_single ? (|regs_q[`REG_R_SINGLE][7:6]) : (|regs_q[`REG_R_BRIDGED][7:6]));
         o_sleep <= sleep_req;
      end
   end

   // ****************************************
   // Checks
   // ****************************************
   a_tone_forces_bridged: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      tone_on |=> (o_input_src == SRC_TONE && o_follower_en && !o_sleep)) else $error("tone path not taken");
   a_single_tristates: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      (!tone_on && cfg_single) |=> (!o_follower_en && o_single_ended_mode)) else $error("single-ended mode wrong");
   a_bridged_follower: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      (!tone_on && !cfg_single) |=> o_follower_en) else $error("bridged follower off");
   a_sleep_mutes: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      (!tone_on && sleep_req) |=> (o_sleep && o_mute)) else $error("sleep not entered");
   a_nomatch_quiet: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      (state_q == ST_SKIP) |=> !o_sda_oe) else $error("SDA driven while ignoring");
   a_start_to_addr: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      start_c |=> (state_q == ST_ADDR && bit_q == 4'hf)) else $error("start missed");
   a_stop_idle: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      (stop_c && !start_c) |=> state_q == ST_IDLE) else $error("stop missed");
   a_write_ack: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      wr_strobe |=> o_sda_oe && !o_sda) else $error("data byte not acked");
endmodule

// File: test/i2c_master_model.sv
// Behavioural two-wire bus master that drives the clock and pulls the data line low
`timescale 1ns/100ps
module i2c_master_model (
   input wire logic i_sys_clk,
   input wire logic i_sda,
   output logic o_scl,
   output logic o_sda_oe
);
   // Quarter of a 400 ns bus clock period, in system clocks
   localparam int QTR = 2;

   // Data line released while idle; the clock is driven high between frames
   initial begin
      o_scl = 1'b1;
      o_sda_oe = 1'b0;
   end

   task automatic wait_q(input int n);
      repeat (n * QTR) @(negedge i_sys_clk);
   endtask

   // ****************************************
   // Frame conditions
   // ****************************************
   task automatic start_cond();
      wait_q(1);
      o_sda_oe = 1'b1;
      wait_q(2);
      o_scl = 1'b0;
      wait_q(1);
   endtask

   task automatic stop_cond();
      o_sda_oe = 1'b1;
      wait_q(1);
      o_scl = 1'b1;
      wait_q(1);
      o_sda_oe = 1'b0;
      wait_q(2);
   endtask

   // ****************************************
   // One clock: data set mid-low, sampled mid-high
   // ****************************************
   task automatic bit_xfer(input logic b, output logic s);
      o_sda_oe = ~b;
      wait_q(1);
      o_scl = 1'b1;
      wait_q(1);
      s = i_sda;
      wait_q(1);
      o_scl = 1'b0;
      wait_q(1);
   endtask

   task automatic write_byte(input logic [7:0] d, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_xfer(d[i], s);
      end
      // Line released so the device can pull it low
      bit_xfer(1'b1, s);
      ack = ~s;
   endtask

   task automatic read_byte(input logic ack, output logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_xfer(1'b1, d[i]);
      end
      bit_xfer(~ack, s);
   endtask
endmodule

// File: test/tb_top.sv
// Self-checking bench for the amplifier mode control block
`timescale 1ns/100ps
`include "amp_ctrl_defines.svh"
module tb_top;
   import amp_ctrl_pkg::*;
   localparam int GAP = 20;
   logic i_sys_clk, i_rst_n, cfg, sleep_n, tone, strap_hi, strap_lo;
   logic scl, m_oe, sda_out, sda_oe, follower_en, single_mode, bank_single, fixed_gain, mute, sleep;
   logic sda_line;
   logic [5:0] gain_r, gain_l;
   src_t src;
   int error_cnt = 0;
   int check_count = 0;

   // Open-drain line with pull-up
   assign sda_line = ~(sda_oe & ~sda_out) & ~m_oe;

   amp_mode_control_i2c_slave #(.GAP_CYC(GAP)) uut (
      .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_scl(scl), .i_sda(sda_line),
      .o_sda(sda_out), .o_sda_oe(sda_oe), .i_output_config_select(cfg),
      .i_sleep_request_n(sleep_n), .i_system_tone_input(tone),
      .i_addr_strap_hi(strap_hi), .i_addr_strap_lo(strap_lo),
      .o_follower_en(follower_en), .o_single_ended_mode(single_mode), .o_input_src(src),
      .o_gain_bank_single(bank_single), .o_tone_fixed_gain(fixed_gain), .o_gain_right(gain_r),
      .o_gain_left(gain_l), .o_mute(mute), .o_sleep(sleep)
   );

   i2c_master_model master (.i_sys_clk(i_sys_clk), .i_sda(sda_line), .o_scl(scl), .o_sda_oe(m_oe));

   initial begin
      i_sys_clk = 1'b0;
      forever #25 i_sys_clk = ~i_sys_clk;
   end

   // ****************************************
   // Helpers
   // ****************************************
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic summarize();
      $display("checks %0d errors %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   task automatic idle(input int n);
      repeat (n) @(negedge i_sys_clk);
   endtask

   task automatic chk_mode(input logic f, input logic s, input src_t p, input logic b);
      check(8'(follower_en), 8'(f));
      check(8'(single_mode), 8'(s));
      check(8'(src), 8'(p));
      check(8'(bank_single), 8'(b));
   endtask

   task automatic wr_regs(input logic [47:0] v);
      logic a;
      master.start_cond();
      master.write_byte({`ADDR_FIXED, strap_hi, strap_lo, 1'b0}, a);
      check(8'(a), 8'h01);
      for (int i = 5; i >= 0; i--) begin
         master.write_byte(v[i*8 +: 8], a);
         check(8'(a), 8'h01);
      end
      master.stop_cond();
      idle(8);
   endtask

   task automatic rd_regs(input logic [47:0] exp);
      logic a;
      logic [7:0] d;
      master.start_cond();
      master.write_byte({`ADDR_FIXED, strap_hi, strap_lo, 1'b1}, a);
      check(8'(a), 8'h01);
      for (int i = 5; i >= 0; i--) begin
         master.read_byte(i != 0, d);
         check(d, exp[i*8 +: 8]);
      end
      check(8'(sda_oe), 8'h00);
      master.stop_cond();
   endtask

   task automatic pulse_tone(input int n);
      repeat (n) begin
         tone = 1'b1;
         idle(4);
         tone = 1'b0;
         idle(4);
      end
   endtask

   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      logic a;
      i_rst_n = 1'b0;
      cfg = 1'b0;
      sleep_n = 1'b1;
      tone = 1'b0;
      strap_hi = 1'b1;
      strap_lo = 1'b0;
      idle(16);
      chk_mode(1'b1, 1'b0, SRC_LINE, 1'b0);
      check(8'(mute), 8'h01);
      check(8'(gain_r), `GAIN_RST);
      i_rst_n = 1'b1;
      idle(10);
      // Pins in control after reset
      cfg = 1'b1;
      idle(8);
      chk_mode(1'b0, 1'b1, SRC_HP, 1'b1);
      cfg = 1'b0;
      idle(8);
      chk_mode(1'b1, 1'b0, SRC_LINE, 1'b0);
      sleep_n = 1'b0;
      idle(8);
      check(8'({sleep, mute}), 8'h03);
      sleep_n = 1'b1;
      idle(8);
      check(8'(sleep), 8'h00);
      // Wrong strap level in the address: ignored until the next start
      master.start_cond();
      master.write_byte({`ADDR_FIXED, strap_hi, ~strap_lo, 1'b0}, a);
      check(8'(a), 8'h00);
      master.write_byte(8'h00, a);
      check(8'(a), 8'h00);
      master.stop_cond();
      // Registers take over with the mask cleared; the pin is then ignored
      wr_regs({8'h05, 8'h0a, 8'h11, 8'h22, 8'h00, 8'h62});
      chk_mode(1'b0, 1'b1, SRC_HP, 1'b1);
      check(8'({gain_r, 2'b00}), 8'h44);
      check(8'(gain_l), 8'h22);
      rd_regs({8'h05, 8'h0a, 8'h11, 8'h22, 8'h00, 8'h62});
      // Sleep from the control bit, then a forced tone wakes it
      wr_regs({8'h05, 8'h0a, 8'h11, 8'h22, 8'h00, 8'h63});
      check(8'({sleep, mute}), 8'h03);
      wr_regs({8'h05, 8'h0a, 8'h11, 8'h22, 8'h00, 8'he3});
      chk_mode(1'b1, 1'b0, SRC_TONE, 1'b1);
      check(8'({fixed_gain, sleep}), 8'h02);
      check(8'(gain_r), 8'h11);
      wr_regs({8'h05, 8'h0a, 8'h11, 8'h22, 8'h00, 8'h63});
      chk_mode(1'b0, 1'b1, SRC_HP, 1'b1);
      check(8'({fixed_gain, sleep}), 8'h01);
      // Auto-detect: seven edges are not enough, the eighth is
      wr_regs({8'h05, 8'h0a, 8'h11, 8'h22, 8'h04, 8'h00});
      pulse_tone(7);
      check(8'(src), 8'(SRC_LINE));
      pulse_tone(1);
      check(8'(src), 8'(SRC_TONE));
      check(8'(fixed_gain), 8'h01);
      idle(2 * GAP + 10);
      chk_mode(1'b1, 1'b0, SRC_LINE, 1'b0);
      check(8'(fixed_gain), 8'h00);
      summarize();
   end

   // Whole run is a few thousand clocks; this limit leaves a wide margin
   initial begin
      repeat (20000) @(posedge i_sys_clk);
      error_cnt++;
      $display("Error at %0t: watchdog expired", $time);
      summarize();
   end
endmodule
